// *** hw/dpmi_pkg.sv ***
// shared constants, types and helpers for the dual-channel mac-side interface
// Notes on behaviour
// - half duplex: tx and rx together flag collision
// - 10M tx collision reported after seven bits
// - collision while receiving is reported at once
// - 10M heartbeat: pulse collision after each packet
// - carrier from squelch or signal detect
// - half duplex carrier on tx or rx
// - carrier drops at end of packet
// - rmii moves two bits per reference clock
// - separate receive valid output in rmii
// - rx error on symbol, false carrier, fifo fault
// - receive data corrupted on any error
// - 10M data every tenth reference clock in rmii or single-clock mode, every fourth in serial mode
// - fifo fault forces error, sets status bits
// - rmii start threshold sets buffer latency
// - single-clock mode threshold table
// - seven-wire serial mode, one bit at 10M
// - single-clock mode runs from reference only
// - separate tx and rx single-clock enables
// - tx and rx port mapping per channel
// - tx may take opposite channel receive data
// - rx mapping: normal, opposite, both, off
// - tx mapping: normal, opposite, cross, off
package dpmi_pkg;
    localparam logic [4:0] PBC_ADDR = 5'h17;
    localparam logic [15:0] PBC_RESET = 16'h0001;
    localparam logic [15:0] PBC_WMASK = 16'h1fe3;
    localparam int RXMAP_LSB = 11;
    localparam int TXMAP_LSB = 9;
    localparam int SER_BIT = 8;
    localparam int SCRX_BIT = 7;
    localparam int SCTX_BIT = 6;
    localparam int RMII_BIT = 5;
    localparam int OVF_BIT = 3;
    localparam int UNF_BIT = 2;
    localparam int THR_LSB = 0;
    localparam logic [1:0] MAP_NORM = 2'h0;
    localparam logic [1:0] MAP_OPP = 2'h1;
    localparam logic [1:0] MAP_ALT = 2'h2;
    localparam logic [1:0] MAP_OFF = 2'h3;
    typedef enum logic [2:0] {SRC_OWN = 3'h1, SRC_OPP = 3'h2, SRC_NONE = 3'h4} dpmi_src_type;
    typedef enum logic [2:0] {EB_IDLE = 3'h1, EB_FILL = 3'h2, EB_RUN = 3'h4} dpmi_eb_state_type;
    localparam int CLK_NS = 25;
    localparam int BIT10_NS = 100;
    localparam int BIT10_CYC = (BIT10_NS + CLK_NS - 1) / CLK_NS;
    localparam int COL_BITS = 7;
    localparam int SQE_GAP_NS = 1000;
    localparam int SQE_GAP_CYC = SQE_GAP_NS / CLK_NS;
    localparam int SQE_BITS = 10;
    localparam int CAD_10M = 10;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] COL_DLY = CNT_W'(COL_BITS * BIT10_CYC);
    localparam logic [CNT_W-1:0] SQE_GAP = CNT_W'(SQE_GAP_CYC);
    localparam logic [CNT_W-1:0] SQE_END = CNT_W'(SQE_GAP_CYC + SQE_BITS * BIT10_CYC);

    // rx port source from own and opposite channel maps
    function automatic dpmi_src_type rx_src(input logic [1:0] own, input logic [1:0] opp);
        case ({own, opp})
            4'h5, 4'h6, 4'h9, 4'hd, 4'he: rx_src = SRC_OPP;
            4'h7, 4'hc, 4'hf: rx_src = SRC_NONE;
            default: rx_src = SRC_OWN;
        endcase
    endfunction

    // start threshold in dibits, rmii or single-clock table
    function automatic logic [3:0] eb_thr(input logic rmii, input logic spd, input logic [1:0] code);
        if (rmii && spd) begin
            case (code)
                2'h1: eb_thr = 4'h1;
                2'h2: eb_thr = 4'h3;
                2'h3: eb_thr = 4'h5;
                default: eb_thr = 4'h7;
            endcase
        end else if (rmii) begin
            case (code)
                2'h2: eb_thr = 4'h2;
                2'h0: eb_thr = 4'h6;
                default: eb_thr = 4'h4;
            endcase
        end else if (spd) begin
            eb_thr = code[1] == code[0] ? 4'h6 : 4'h2;
        end else begin
            eb_thr = 4'h4;
        end
    endfunction

    // cycles between data slots
    function automatic logic [CNT_W-1:0] cad_period(input logic spd, input logic ser);
        if (ser) begin
            cad_period = CNT_W'(BIT10_CYC);
        end else if (spd) begin
            cad_period = CNT_ONE;
        end else begin
            cad_period = CNT_W'(CAD_10M);
        end
    endfunction
endpackage

// *** hw/dpmi_ebuf.sv ***
// receive elasticity buffer between recovered link clock and reference clock
`timescale 1ns/100ps
module dpmi_ebuf import dpmi_pkg::*; #(
    parameter int W = 3,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic lclk_i,
    input wire logic [W-1:0] ldata_i,
    input wire logic lvalid_i,
    input wire logic tick_i,
    input wire logic [3:0] thr_i,
    output logic [W-1:0] data_o,
    output logic valid_o,
    output logic unf_o,
    output logic ovf_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [W+1:0] s1_reg, s2_reg;
    logic lprev_reg;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    dpmi_eb_state_type st_reg, st_next;
    logic [W-1:0] data_next;
    logic valid_next, unf_next, ovf_next, wr, rd, empty, full;

    // two flops on clock, valid and data; only s2 is looked at
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            lprev_reg <= 1'b0;
        end else begin
            s1_reg <= {lclk_i, lvalid_i, ldata_i};
            s2_reg <= s1_reg;
            lprev_reg <= s2_reg[W+1];
        end
    end

    // write on each rising link edge while valid is set, read on the cadence tick
    always_comb begin
        empty = cnt_reg == '0;
        full = cnt_reg == FULL;
        wr = s2_reg[W+1] && !lprev_reg && s2_reg[W];
        rd = 1'b0;
        st_next = st_reg;
        data_next = data_o;
        valid_next = valid_o;
        unf_next = 1'b0;
        ovf_next = wr && full;
        case (st_reg)
            EB_IDLE: begin
                valid_next = 1'b0;
                if (wr) begin
                    st_next = EB_FILL;
                end
            end
            EB_FILL: begin
                if (cnt_reg >= (AW+1)'(thr_i)) begin
                    st_next = EB_RUN;
                end
            end
            EB_RUN: begin
                if (tick_i && !empty) begin
                    rd = 1'b1;
                    data_next = mem[rp_reg];
                    valid_next = 1'b1;
                end else if (tick_i && s2_reg[W]) begin
                    unf_next = 1'b1;
                end else if (tick_i) begin
                    valid_next = 1'b0;
                    st_next = EB_IDLE;
                end
            end
            default: st_next = EB_IDLE;
        endcase
        wp_next = (wr && !full) ? wp_reg + 1'b1 : wp_reg;
        rp_next = rd ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(wr && !full) - (AW+1)'(rd);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= EB_IDLE;
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            data_o <= '0;
            valid_o <= 1'b0;
            unf_o <= 1'b0;
            ovf_o <= 1'b0;
        end else begin
            st_reg <= st_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            data_o <= data_next;
            valid_o <= valid_next;
            unf_o <= unf_next;
            ovf_o <= ovf_next;
        end
    end

    // storage has no reset; contents are only read once written
    always_ff @(posedge core_clk_i) begin
        if (wr && !full) begin
            mem[wp_reg] <= s2_reg[W-1:0];
        end
    end

    eb_overrun_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        wr && full |=> ovf_o) else $error("overrun not flagged");
    eb_underrun_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        st_reg == EB_RUN && tick_i && empty && s2_reg[W] |=> unf_o && valid_o) else $error("underrun not flagged");
endmodule

// *** hw/dpmi_if.sv ***
// mac-side data interface: collision, carrier, cadence, buffering and port mapping
`timescale 1ns/100ps
module dpmi_if import dpmi_pkg::*; #(
    parameter int EB_DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_ch_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [1:0] ch_speed100_i,
    input wire logic [1:0] ch_full_duplex_i,
    input wire logic [1:0] ch_heartbeat_en_i,
    input wire logic [1:0] ch_squelch_ok_i,
    input wire logic [1:0] ch_signal_detect_i,
    input wire logic [1:0] ch_two_zeros_i,
    input wire logic [1:0] ch_false_carrier_i,
    input wire logic [1:0] ch_rx_lclk_i,
    input wire logic [1:0][1:0] ch_rx_data_i,
    input wire logic [1:0] ch_rx_valid_i,
    input wire logic [1:0] ch_sym_err_i,
    output logic [1:0] ch_tx_en_o,
    output logic [1:0][1:0] ch_txd_o,
    input wire logic [1:0] mac_tx_en_i,
    input wire logic [1:0][1:0] mac_txd_i,
    output logic [1:0][1:0] mac_rxd_o,
    output logic [1:0] mac_rx_dv_o,
    output logic [1:0] mac_crs_dv_o,
    output logic [1:0] mac_rx_er_o,
    output logic [1:0] mac_crs_o,
    output logic [1:0] mac_col_o
);
    logic [1:0][15:0] cfg_reg, cfg_next;
    logic [1:0] unf_reg, unf_next, ovf_reg, ovf_next;
    logic [15:0] rdata_next;
    logic [1:0] rxf_reg, rxf_next, txp_reg, txp_next, errf_reg, errf_next;
    logic [1:0][CNT_W-1:0] colc_reg, colc_next, sqec_reg, sqec_next, cad_reg, cad_next;
    logic [1:0] ctx_en_next;
    logic [1:0][1:0] ctxd_next, prxd_next;
    logic [1:0] pdv_next, pcrsdv_next, per_next, pcrs_next, pcol_next;
    logic [1:0] rmii, sctx, scrx, ser, spd, fd;
    logic [1:0][1:0] rxmap, txmap, thr;
    logic [1:0] rx_act, coll, col_c, sqe_c, crs_c, tick, ch_rxer;
    logic [1:0][2:0] eb_data;
    logic [1:0] eb_valid, eb_unf, eb_ovf;
    logic [1:0][1:0] ch_rxd;
    dpmi_src_type [1:0] psrc;

    // configuration fields
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            rmii[i] = cfg_reg[i][RMII_BIT];
            sctx[i] = cfg_reg[i][SCTX_BIT];
            scrx[i] = cfg_reg[i][SCRX_BIT];
            ser[i] = cfg_reg[i][SER_BIT];
            rxmap[i] = cfg_reg[i][RXMAP_LSB +: 2];
            txmap[i] = cfg_reg[i][TXMAP_LSB +: 2];
            thr[i] = cfg_reg[i][THR_LSB +: 2];
            spd[i] = ch_speed100_i[i];
            fd[i] = ch_full_duplex_i[i];
        end
    end

    // register port; status sticky, cleared by read, a new event wins
    always_comb begin
        cfg_next = cfg_reg;
        unf_next = unf_reg | eb_unf;
        ovf_next = ovf_reg | eb_ovf;
        rdata_next = reg_rdata_o;
        if (reg_wr_i && reg_addr_i == PBC_ADDR) begin
            cfg_next[reg_ch_i] = (reg_wdata_i & PBC_WMASK) | (cfg_reg[reg_ch_i] & ~PBC_WMASK);
        end
        if (reg_rd_i) begin
            rdata_next = 16'h0000;
            if (reg_addr_i == PBC_ADDR) begin
                rdata_next = cfg_reg[reg_ch_i];
                rdata_next[UNF_BIT] = unf_reg[reg_ch_i];
                rdata_next[OVF_BIT] = ovf_reg[reg_ch_i];
                unf_next[reg_ch_i] = eb_unf[reg_ch_i];
                ovf_next[reg_ch_i] = eb_ovf[reg_ch_i];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_reg <= {PBC_RESET, PBC_RESET};
            unf_reg <= 2'h0;
            ovf_reg <= 2'h0;
            reg_rdata_o <= 16'h0000;
        end else begin
            cfg_reg <= cfg_next;
            unf_reg <= unf_next;
            ovf_reg <= ovf_next;
            reg_rdata_o <= rdata_next;
        end
    end

    // per-channel carrier, collision, heartbeat, cadence and tx source
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            rx_act[i] = spd[i] ? (ch_signal_detect_i[i] && ch_two_zeros_i[i]) : ch_squelch_ok_i[i];
            coll[i] = !fd[i] && ch_tx_en_o[i] && rx_act[i];
            // receive seen first skips the noise filter
            rxf_next[i] = rx_act[i] && (rxf_reg[i] || !ch_tx_en_o[i]);
            colc_next[i] = !coll[i] ? '0 : (colc_reg[i] == COL_DLY ? colc_reg[i] : colc_reg[i] + CNT_ONE);
            col_c[i] = coll[i] && (spd[i] || rxf_reg[i] || colc_reg[i] == COL_DLY);
            txp_next[i] = ch_tx_en_o[i];
            if (txp_reg[i] && !ch_tx_en_o[i] && !spd[i] && ch_heartbeat_en_i[i]) begin
                sqec_next[i] = CNT_ONE;
            end else if (sqec_reg[i] != '0 && sqec_reg[i] < SQE_END) begin
                sqec_next[i] = sqec_reg[i] + CNT_ONE;
            end else begin
                sqec_next[i] = '0;
            end
            sqe_c[i] = sqec_reg[i] > SQE_GAP;
            crs_c[i] = rx_act[i] || (!fd[i] && ch_tx_en_o[i]);
            tick[i] = cad_reg[i] == '0;
            // 10M slots every tenth clock in rmii or single-clock mode, every fourth clock in serial mode
            cad_next[i] = tick[i] ? cad_period(spd[i] || !(rmii[i] | sctx[i] | scrx[i]), ser[i]) - CNT_ONE
                                  : cad_reg[i] - CNT_ONE;
            ctx_en_next[i] = ch_tx_en_o[i];
            ctxd_next[i] = ch_txd_o[i];
            if (tick[i]) begin
                case (txmap[i])
                    MAP_NORM: begin
                        ctx_en_next[i] = mac_tx_en_i[i];
                        ctxd_next[i] = mac_txd_i[i];
                    end
                    MAP_OPP: begin
                        ctx_en_next[i] = mac_tx_en_i[1-i];
                        ctxd_next[i] = mac_txd_i[1-i];
                    end
                    MAP_ALT: begin
                        // cross path only when this channel runs rmii or single-clock transmit
                        ctx_en_next[i] = (rmii[i] | sctx[i]) && eb_valid[1-i];
                        ctxd_next[i] = ch_rxd[1-i];
                    end
                    default: begin
                        ctx_en_next[i] = 1'b0;
                        ctxd_next[i] = 2'h0;
                    end
                endcase
                if (ser[i]) begin
                    ctxd_next[i][1] = 1'b0;
                end
            end
            // fifo fault taints the rest of the frame
            errf_next[i] = (eb_valid[i] || eb_unf[i] || eb_ovf[i]) && (errf_reg[i] || eb_unf[i] || eb_ovf[i]);
            ch_rxer[i] = (eb_valid[i] && (eb_data[i][2] || errf_reg[i])) || ch_false_carrier_i[i];
            ch_rxd[i] = ch_rxer[i] ? ~eb_data[i][1:0] : eb_data[i][1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rxf_reg <= 2'h0;
            txp_reg <= 2'h0;
            errf_reg <= 2'h0;
            colc_reg <= '0;
            sqec_reg <= '0;
            cad_reg <= '0;
            ch_tx_en_o <= 2'h0;
            ch_txd_o <= '0;
        end else begin
            rxf_reg <= rxf_next;
            txp_reg <= txp_next;
            errf_reg <= errf_next;
            colc_reg <= colc_next;
            sqec_reg <= sqec_next;
            cad_reg <= cad_next;
            ch_tx_en_o <= ctx_en_next;
            ch_txd_o <= ctxd_next;
        end
    end

    // one buffer per channel; recovered clock is sampled, not used as a clock
    for (genvar g = 0; g < 2; g++) begin : g_eb
        dpmi_ebuf #(.W(3), .DEPTH(EB_DEPTH)) u_eb (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .lclk_i(ch_rx_lclk_i[g]),
            .ldata_i({ch_sym_err_i[g], ch_rx_data_i[g]}),
            .lvalid_i(ch_rx_valid_i[g]),
            .tick_i(tick[g]),
            .thr_i(eb_thr(rmii[g], spd[g], thr[g])),
            .data_o(eb_data[g]),
            .valid_o(eb_valid[g]),
            .unf_o(eb_unf[g]),
            .ovf_o(eb_ovf[g])
        );
    end

    // rx port routing; an unowned port stays quiet
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            psrc[p] = rx_src(rxmap[p], rxmap[1-p]);
            prxd_next[p] = 2'h0;
            pdv_next[p] = 1'b0;
            pcrsdv_next[p] = 1'b0;
            per_next[p] = 1'b0;
            pcrs_next[p] = 1'b0;
            pcol_next[p] = 1'b0;
            if (psrc[p] != SRC_NONE) begin
                for (int c = 0; c < 2; c++) begin
                    if ((c == p) == (psrc[p] == SRC_OWN)) begin
                        prxd_next[p] = ch_rxd[c];
                        if (ser[c]) begin
                            prxd_next[p][1] = 1'b0;
                        end
                        pdv_next[p] = eb_valid[c];
                        pcrsdv_next[p] = eb_valid[c] || rx_act[c];
                        per_next[p] = ch_rxer[c];
                        pcrs_next[p] = crs_c[c];
                        pcol_next[p] = col_c[c] || sqe_c[c];
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mac_rxd_o <= '0;
            mac_rx_dv_o <= 2'h0;
            mac_crs_dv_o <= 2'h0;
            mac_rx_er_o <= 2'h0;
            mac_crs_o <= 2'h0;
            mac_col_o <= 2'h0;
        end else begin
            mac_rxd_o <= prxd_next;
            mac_rx_dv_o <= pdv_next;
            mac_crs_dv_o <= pcrsdv_next;
            mac_rx_er_o <= per_next;
            mac_crs_o <= pcrs_next;
            mac_col_o <= pcol_next;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_chk
        coll_fast_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            coll[g] && spd[g] |-> col_c[g]) else $error("100M collision missed");
        coll_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            coll[g] && !spd[g] && !rxf_reg[g] && colc_reg[g] < COL_DLY |-> !col_c[g]) else $error("early collision");
        rx_coll_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            coll[g] && rxf_reg[g] |-> col_c[g]) else $error("rx collision late");
        hb_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            $fell(ch_tx_en_o[g]) && !spd[g] && ch_heartbeat_en_i[g] |-> ##40 !sqe_c[g] ##1 sqe_c[g])
            else $error("heartbeat timing wrong");
        crs_full_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            fd[g] && !rx_act[g] |-> !crs_c[g]) else $error("full duplex carrier on tx");
        crs_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            $fell(crs_c[g]) |-> !rx_act[g] && !(ch_tx_en_o[g] && !fd[g])) else $error("carrier mismatch");
        slot_10m_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            tick[g] && !spd[g] && rmii[g] && !ser[g] && $stable(cfg_reg[g]) |->
            ##1 !tick[g] [*8] ##1 !tick[g] ##1 tick[g]) else $error("10M cadence wrong");
        err_frame_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            eb_unf[g] |=> errf_reg[g] || !eb_valid[g]) else $error("fault not latched");
        err_corrupt_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            ch_rxer[g] |-> ch_rxd[g] == ~eb_data[g][1:0]) else $error("data not corrupted");
        port_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            psrc[g] == SRC_NONE |=> !mac_rx_dv_o[g] && !mac_crs_o[g] && !mac_rx_er_o[g])
            else $error("unowned port active");
    end
endmodule

// *** bench/dpmi_mac_model.sv ***
// mac partner model: one transmit port driver and one receive port monitor
`timescale 1ns/100ps
module dpmi_mac_model (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [1:0] d_i,
    input wire logic [3:0] per_i,
    output logic tx_en_o,
    output logic [1:0] txd_o,
    input wire logic [1:0] rxd_i,
    input wire logic rx_dv_i,
    input wire logic rx_er_i,
    output logic [7:0] rx_n_o,
    output logic [7:0] er_n_o,
    output logic [15:0] rx_sr_o
);
    logic [3:0] cnt = 4'h0;
    initial begin
        tx_en_o = 1'b0;
        txd_o = 2'h0;
        rx_n_o = 8'h00;
        er_n_o = 8'h00;
        rx_sr_o = 16'h0000;
    end
    // send is driven on the falling edge, so it is taken on the rising edge to avoid a race;
    // the non-blocking update reaches the design one edge later; idle data flips so stale bits never pass for a frame
    always @(posedge clk_i) begin
        tx_en_o <= send_i;
        txd_o <= send_i ? d_i : ~txd_o;
    end
    // one sample per slot, counted from the rise of valid since the mac cannot see the tick
    always @(posedge clk_i) begin
        cnt <= (!rx_dv_i || cnt == per_i - 4'h1) ? 4'h0 : cnt + 4'h1;
        if (rx_dv_i && cnt == 4'h0) begin
            rx_sr_o <= {rx_sr_o[13:0], rxd_i};
            rx_n_o <= rx_n_o + 8'h01;
        end
        if (rx_er_i) begin
            er_n_o <= er_n_o + 8'h01;
        end
    end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench: registers, port mapping, collision, carrier and receive buffer
`timescale 1ns/100ps
module tb_top;
    import dpmi_pkg::*;
    typedef struct packed {logic [15:0] c0; logic [15:0] c1; logic [3:0] d; logic [1:0] xe; logic [3:0] xd;} dpmi_row_type;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_s = 1'b0, rd_s = 1'b0, ch = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] spd = 2'h3, fd = 2'h0, hb = 2'h0, sq = 2'h0, sdet = 2'h0, tz = 2'h0, fc = 2'h0;
    logic [1:0] lclk = 2'h0, rv = 2'h0, se = 2'h0, send = 2'h0;
    logic [1:0][1:0] rxd_in = 4'h0;
    logic [3:0] md = 4'h0, per = 4'ha;
    int mismatches = 0, n_checks = 0, t;
    wire [15:0] rdata, sr0, sr1;
    wire [1:0] tx_en, rx_dv, crs_dv, rx_er, crs, col, men;
    wire [1:0][1:0] txd, rxd, mtxd;
    wire [7:0] rn0, rn1, en0, en1;
    wire [3:0] obs = {col, crs};
    // tx mapping rows: normal, swap, broadcast from port a, off, cross path refused without rmii
    dpmi_row_type rows [5] = '{'{16'h0001, 16'h0001, 4'h6, 2'h3, 4'h6}, '{16'h0201, 16'h0201, 4'h6, 2'h3, 4'h9},
        '{16'h0001, 16'h0201, 4'h6, 2'h3, 4'ha}, '{16'h0601, 16'h0601, 4'h6, 2'h0, 4'h0},
        '{16'h0401, 16'h0401, 4'h6, 2'h0, 4'h0}};
    always #12.5 clk = ~clk;
    dpmi_if dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_ch_i(ch),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ch_speed100_i(spd), .ch_full_duplex_i(fd),
        .ch_heartbeat_en_i(hb), .ch_squelch_ok_i(sq), .ch_signal_detect_i(sdet), .ch_two_zeros_i(tz),
        .ch_false_carrier_i(fc), .ch_rx_lclk_i(lclk), .ch_rx_data_i(rxd_in), .ch_rx_valid_i(rv), .ch_sym_err_i(se),
        .ch_tx_en_o(tx_en), .ch_txd_o(txd), .mac_tx_en_i(men), .mac_txd_i(mtxd), .mac_rxd_o(rxd),
        .mac_rx_dv_o(rx_dv), .mac_crs_dv_o(crs_dv), .mac_rx_er_o(rx_er), .mac_crs_o(crs), .mac_col_o(col));
    dpmi_mac_model m0 (.clk_i(clk), .send_i(send[0]), .d_i(md[1:0]), .per_i(per), .tx_en_o(men[0]), .txd_o(mtxd[0]),
        .rxd_i(rxd[0]), .rx_dv_i(rx_dv[0]), .rx_er_i(rx_er[0]), .rx_n_o(rn0), .er_n_o(en0), .rx_sr_o(sr0));
    dpmi_mac_model m1 (.clk_i(clk), .send_i(send[1]), .d_i(md[3:2]), .per_i(per), .tx_en_o(men[1]), .txd_o(mtxd[1]),
        .rxd_i(rxd[1]), .rx_dv_i(rx_dv[1]), .rx_er_i(rx_er[1]), .rx_n_o(rn1), .er_n_o(en1), .rx_sr_o(sr1));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic c, input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        {ch, addr, wdata, wr_s} = {c, a, d, 1'b1};
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    // read data stands until the next read, so it is looked at one full cycle later
    task automatic rd(input logic c, input logic [4:0] a, input logic [15:0] exp);
        @(negedge clk);
        {ch, addr, rd_s} = {c, a, 1'b1};
        @(negedge clk);
        rd_s = 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // bounded wait on one carrier or collision bit; running out ends the run
    task automatic wait_obs(input int idx, input logic val, input int lim, output int n);
        n = 0;
        while (obs[idx] !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(16'(obs[idx]), 16'(val));
        if (obs[idx] !== val) close_out();
    endtask
    // link clock of 200 ns runs only inside the frame; data set while it is low
    task automatic frame(input int n, input int err_at);
        for (int k = 0; k < n; k++) begin
            {rxd_in[0], rv[0], se[0]} = {2'(k), 1'b1, 1'(k == err_at)};
            repeat (4) @(negedge clk);
            lclk[0] = 1'b1;
            repeat (4) @(negedge clk);
            lclk[0] = 1'b0;
        end
        {rxd_in[0], rv[0], se[0]} = {~rxd_in[0], 2'h0};
        repeat (80) @(negedge clk);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        chk(16'({tx_en, rx_dv, crs_dv, rx_er, crs, col}), 16'h0000);
        rst_b = 1'b1;
        rd(0, PBC_ADDR, PBC_RESET);
        rd(1, PBC_ADDR, PBC_RESET);
        wr(0, 5'h16, 16'hffff);
        rd(0, 5'h16, 16'h0000);
        rd(0, PBC_ADDR, PBC_RESET);
        wr(0, PBC_ADDR, 16'hffff);
        rd(0, PBC_ADDR, PBC_WMASK);
        foreach (rows[i]) begin
            wr(0, PBC_ADDR, rows[i].c0);
            wr(1, PBC_ADDR, rows[i].c1);
            {send, md} = {2'h3, rows[i].d};
            repeat (4) @(negedge clk);
            chk(16'({tx_en, txd}), 16'({rows[i].xe, rows[i].xd}));
        end
        send = 2'h0;
        wr(0, PBC_ADDR, PBC_RESET);
        wr(1, PBC_ADDR, PBC_RESET);
        {sdet, tz} = 4'h5;
        wait_obs(0, 1'b1, 4, t);
        chk(16'(crs_dv[0]), 16'h1);
        send[0] = 1'b1;
        wait_obs(2, 1'b1, 3, t);
        {sdet, tz} = 4'h0;
        wait_obs(2, 1'b0, 4, t);
        chk(16'(crs[0]), 16'h1);
        send[0] = 1'b0;
        wait_obs(0, 1'b0, 4, t);
        {fd, send} = 4'h5;
        repeat (4) @(negedge clk);
        chk(16'(crs[0]), 16'h0);
        {sdet, tz} = 4'h5;
        repeat (6) @(negedge clk);
        chk(16'(col[0]), 16'h0);
        {sdet, tz, fd, spd, hb} = 10'h01;
        repeat (4) @(negedge clk);
        sq[0] = 1'b1;
        wait_obs(2, 1'b1, 40, t);
        chk(16'(t >= 26 && t <= 31), 16'h1);
        sq[0] = 1'b0;
        wait_obs(2, 1'b0, 4, t);
        send[0] = 1'b0;
        wait_obs(2, 1'b1, 60, t);
        chk(16'(t >= 39 && t <= 44), 16'h1);
        wait_obs(2, 1'b0, 50, t);
        chk(16'(t >= 36 && t <= 44), 16'h1);
        hb = 2'h0;
        wr(0, PBC_ADDR, 16'h1021);
        wr(1, PBC_ADDR, 16'h1821);
        frame(6, 99);
        chk(16'({rn0, rn1}), 16'h0606);
        chk(16'(sr0[11:0]), 16'h01b1);
        chk(16'(sr1[11:0]), 16'h01b1);
        frame(6, 2);
        chk(16'(en0 != 8'h00 && sr0[11:0] != 12'h1b1), 16'h1);
        {spd, per} = 6'h31;
        wr(0, PBC_ADDR, 16'h0021);
        frame(4, 99);
        chk(16'(rn1), 16'h000c);
        rd(0, PBC_ADDR, 16'h0025);
        rd(0, PBC_ADDR, 16'h0021);
        close_out();
    end
endmodule
